// ==== hw/tes_defs.svh ====
// trigger and event status constants
`ifndef TES_DEFS_SVH
`define TES_DEFS_SVH

// ****************************************
// trigger type codes
// ****************************************
`define TES_TYPE_INTERNAL 3'h1
`define TES_TYPE_EXT_FAST 3'h2
`define TES_TYPE_EXT_SETTLE 3'h3
`define TES_TYPE_REAR_FAST 3'h4
`define TES_TYPE_REAR_SETTLE 3'h5
`define TES_TYPE_RESET 3'h1

// ****************************************
// reading rate codes
// ****************************************
`define TES_RATE_SLOW 2'h0
`define TES_RATE_MEDIUM 2'h1
`define TES_RATE_FAST 2'h2

// ****************************************
// event status latch bit positions
// ****************************************
`define TES_EV_OPC 0
`define TES_EV_UNUSED1 1
`define TES_EV_QUERY 2
`define TES_EV_DEVICE 3
`define TES_EV_EXEC 4
`define TES_EV_CMD 5
`define TES_EV_UNUSED6 6
`define TES_EV_POWER 7
`define TES_ESR_RESET 8'h80
`define TES_ESR_WRITABLE 8'hBD
`define TES_ESE_RESET 8'h00
`define TES_SRE_RESET 8'h00

// ****************************************
// status byte bit positions
// ****************************************
`define TES_STB_MAV 4
`define TES_STB_ESB 5
`define TES_STB_MSS 6
`define TES_SRE_USED 8'hBE

// ****************************************
// timing
// ****************************************
`define TES_CLK_HZ 25000000
`define TES_CLK_MHZ 25
`define TES_RATE_SLOW_DECI 25
`define TES_RATE_MEDIUM_DECI 200
`define TES_RATE_FAST_DECI 1000
`define TES_SETTLE_US 1000

`endif

// ==== hw/tes_pkg.sv ====
// trigger and event status types
package tes_pkg;

    typedef logic [2:0] tes_trig_type_t;

    typedef enum logic {
        TES_ST_IDLE,
        TES_ST_SETTLE
    } tes_seq_st_t;

    // one-cycle event pulses from the command interpreter
    typedef struct packed {
        logic opc_done;
        logic read_no_reply;
        logic line_before_read;
        logic buffers_full;
        logic cal_bad_input;
        logic rx_overflow;
        logic exec_fault;
        logic cmd_fault;
    } tes_events_t;

    // one-cycle command pulses from the command interpreter
    typedef struct packed {
        logic set_type;
        logic [2:0] type_val;
        logic trg;
        logic esr_query;
        logic cls;
        logic cls_first;
        logic ese_we;
        logic sre_we;
        logic [7:0] wdata;
    } tes_cmd_t;

endpackage : tes_pkg

// ==== hw/tes_sync.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module tes_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pin and clean level
    input wire logic pin,
    output logic level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // change counts once the last two stages agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_r <= 1'b0;
        end else if (s2_r == s3_r) begin
            level_r <= s3_r;
        end
    end

    assign level = level_r;
endmodule : tes_sync

// ==== hw/tes_top.sv ====
// trigger selection and event status register bank
// Function
// [RULE1] type 1 launches measurements continuously from the internal timer
// [RULE2] types 2 and 3 trigger externally with the rear pin disabled
// [RULE3] types 4 and 5 trigger externally, a rear pin pulse starts one
// [RULE4] types 3 and 5 insert a settling delay, types 2 and 4 do not
// [RULE5] every external type accepts the trigger command, one measurement each
// [RULE6] key presses count only in local operation with type 2 or 3
// [RULE7] remote with type 4 or 5 stays external, rear pin triggers
// [RULE8] the type command sets the type used for all later measurements
// [RULE9] with rear triggering, one measurement per pulse on the spare pin
// [RULE10] internal rates give 2.5, 20 and 100 readings per second
// [RULE11] status byte built from service mask, event latch, event mask, reply state
// [RULE12] status byte and event latch read-only, both masks read-write
// [RULE13] each event bit latches to 1 until read or cleared
// [RULE14] event mask bit 1 enables, 0 masks the same event bit
// [RULE15] summary bit set when an enabled event bit rises
// [RULE16] event latch query or clear-status returns summary bit to 0
// [RULE17] bit 0 set when operation complete has finished
// [RULE18] bit 2 set on empty read, unread reply, or full buffers
// [RULE19] bit 3 set on bad calibration input or serial input overflow
// [RULE20] bit 4 set when a command cannot be executed
// [RULE21] bit 5 set when a command is not understood
// [RULE22] bit 7 set after power cycle, bits 1 and 6 read 0
// [RULE23] event latch query returns the value then clears it
// [RULE24] status bit 4 set on reply placed, cleared when terminator sent
// [RULE25] type 1 ignores key, rear pin and command trigger requests
`timescale 1ns/10ps
`include "tes_defs.svh"
module tes_top
    import tes_pkg::*;
#(
    parameter int SLOW_CYC = `TES_CLK_HZ * 10 / `TES_RATE_SLOW_DECI,
    parameter int MEDIUM_CYC = `TES_CLK_HZ * 10 / `TES_RATE_MEDIUM_DECI,
    parameter int FAST_CYC = `TES_CLK_HZ * 10 / `TES_RATE_FAST_DECI,
    parameter int SETTLE_CYC = `TES_CLK_MHZ * `TES_SETTLE_US
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins
    input wire logic key_trig_pin,
    input wire logic rear_trig_pin,
    // operating state
    input wire logic remote_mode,
    input wire logic [1:0] rate_sel,
    // command interpreter
    input wire tes_cmd_t cmd,
    input wire tes_events_t events,
    input wire logic reply_placed,
    input wire logic terminator_sent,
    // measurement control
    output logic meas_start,
    output logic settling,
    output tes_trig_type_t trig_type,
    // register read data
    output logic [7:0] event_status_latch,
    output logic [7:0] esr_read_data,
    output logic [7:0] event_enable_mask,
    output logic [7:0] service_request_mask,
    output logic [7:0] summary_status_byte
);
    localparam int CW = 24;

    if (SLOW_CYC < 1 || SLOW_CYC >= (1 << CW) || MEDIUM_CYC < 1 || MEDIUM_CYC >= (1 << CW)
        || FAST_CYC < 1 || FAST_CYC >= (1 << CW) || SETTLE_CYC < 1
        || SETTLE_CYC >= (1 << CW)) begin : g_bad_count
        $error("tes_top: cycle count out of counter range");
    end

    // ****************************************
    // pin synchronisers and edges
    // ****************************************
    logic key_lvl;
    logic rear_lvl;
    logic key_lvl_d_r;
    logic rear_lvl_d_r;
    logic key_edge;
    logic rear_edge;

    tes_sync u_key_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin(key_trig_pin),
        .level(key_lvl)
    );

    tes_sync u_rear_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin(rear_trig_pin),
        .level(rear_lvl)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            key_lvl_d_r <= 1'b0;
            rear_lvl_d_r <= 1'b0;
        end else begin
            key_lvl_d_r <= key_lvl;
            rear_lvl_d_r <= rear_lvl;
        end
    end

    assign key_edge = key_lvl & ~key_lvl_d_r;
    assign rear_edge = rear_lvl & ~rear_lvl_d_r;

    // ****************************************
    // trigger type
    // ****************************************
    tes_trig_type_t type_r;
    logic type_ok;
    logic type_bad;

    function automatic logic is_type(input logic [2:0] t, input logic [2:0] a,
                                     input logic [2:0] b);
        is_type = (t == a) || (t == b);
    endfunction : is_type

    assign type_ok = (cmd.type_val >= `TES_TYPE_INTERNAL)
                   && (cmd.type_val <= `TES_TYPE_REAR_SETTLE);
    assign type_bad = cmd.set_type & ~type_ok;

    // [RULE8] adopt valid type
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            type_r <= `TES_TYPE_RESET;
        end else if (cmd.set_type && type_ok) begin
            type_r <= cmd.type_val;
        end
    end

    // ****************************************
    // external request decode
    // ****************************************
    logic key_ok;
    logic rear_ok;
    logic ext_req;
    logic need_settle;

    // [RULE6] key only local, type 2 or 3
    assign key_ok = key_edge & ~remote_mode
                  & is_type(type_r, `TES_TYPE_EXT_FAST, `TES_TYPE_EXT_SETTLE);
    // [RULE3] [RULE7] [RULE9] rear pin for types 4 and 5
    assign rear_ok = rear_edge & is_type(type_r, `TES_TYPE_REAR_FAST, `TES_TYPE_REAR_SETTLE);
    // [RULE2] [RULE5] [RULE25] command trigger in external types only
    assign ext_req = (type_r != `TES_TYPE_INTERNAL) && !cmd.set_type
                   && (key_ok || rear_ok || cmd.trg);
    // [RULE4] settle for types 3 and 5
    assign need_settle = is_type(type_r, `TES_TYPE_EXT_SETTLE, `TES_TYPE_REAR_SETTLE);

    // ****************************************
    // internal timer
    // ****************************************
    logic [CW-1:0] int_cnt_r;
    logic [CW-1:0] int_period;
    logic int_fire;

    // [RULE10] period per reading rate
    always_comb begin
        case (rate_sel)
            `TES_RATE_SLOW: int_period = CW'(SLOW_CYC - 1);
            `TES_RATE_MEDIUM: int_period = CW'(MEDIUM_CYC - 1);
            default: int_period = CW'(FAST_CYC - 1);
        endcase
    end

    // [RULE1] continuous internal launches
    assign int_fire = (type_r == `TES_TYPE_INTERNAL) && !cmd.set_type && (int_cnt_r == '0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_cnt_r <= '0;
        end else if (type_r != `TES_TYPE_INTERNAL || cmd.set_type) begin
            int_cnt_r <= '0;
        end else if (int_fire) begin
            int_cnt_r <= int_period;
        end else begin
            int_cnt_r <= int_cnt_r - CW'(1);
        end
    end

    // ****************************************
    // settling sequencer
    // ****************************************
    tes_seq_st_t st_r;
    logic [CW-1:0] settle_cnt_r;
    logic settle_done;

    assign settle_done = (st_r == TES_ST_SETTLE) && (settle_cnt_r == '0);

    // [RULE4] delay before the launch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= TES_ST_IDLE;
            settle_cnt_r <= '0;
        end else if (cmd.set_type) begin
            st_r <= TES_ST_IDLE;
            settle_cnt_r <= '0;
        end else begin
            case (st_r)
                TES_ST_IDLE: begin
                    if (ext_req && need_settle) begin
                        st_r <= TES_ST_SETTLE;
                        settle_cnt_r <= CW'(SETTLE_CYC - 1);
                    end
                end
                TES_ST_SETTLE: begin
                    if (settle_done) begin
                        st_r <= TES_ST_IDLE;
                    end else begin
                        settle_cnt_r <= settle_cnt_r - CW'(1);
                    end
                end
                default: st_r <= TES_ST_IDLE;
            endcase
        end
    end

    logic meas_start_r;

    // [RULE5] one launch per accepted request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meas_start_r <= 1'b0;
        end else begin
            meas_start_r <= int_fire || settle_done
                          || (st_r == TES_ST_IDLE && ext_req && !need_settle);
        end
    end

    // ****************************************
    // event status latch and masks
    // ****************************************
    logic [7:0] esr_r;
    logic [7:0] ese_r;
    logic [7:0] sre_r;
    logic [7:0] ev_bits;
    logic [7:0] esr_rd_r;
    logic esr_clr;

    // [RULE17] [RULE18] [RULE19] [RULE20] [RULE21] event mapping
    always_comb begin
        ev_bits = 8'h00;
        ev_bits[`TES_EV_OPC] = events.opc_done;
        ev_bits[`TES_EV_QUERY] = events.read_no_reply | events.line_before_read
                               | events.buffers_full;
        ev_bits[`TES_EV_DEVICE] = events.cal_bad_input | events.rx_overflow;
        ev_bits[`TES_EV_EXEC] = events.exec_fault | type_bad;
        ev_bits[`TES_EV_CMD] = events.cmd_fault;
    end

    assign esr_clr = cmd.esr_query | cmd.cls;

    // [RULE13] [RULE22] [RULE23] sticky, set wins over clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            esr_r <= `TES_ESR_RESET;
        end else begin
            esr_r <= ((esr_clr ? 8'h00 : esr_r) | ev_bits) & `TES_ESR_WRITABLE;
        end
    end

    // [RULE23] capture value before clearing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            esr_rd_r <= 8'h00;
        end else if (cmd.esr_query) begin
            esr_rd_r <= esr_r;
        end
    end

    // [RULE12] writable masks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ese_r <= `TES_ESE_RESET;
            sre_r <= `TES_SRE_RESET;
        end else begin
            if (cmd.ese_we) begin
                ese_r <= cmd.wdata;
            end
            if (cmd.sre_we) begin
                sre_r <= cmd.wdata & `TES_SRE_USED;
            end
        end
    end

    // ****************************************
    // status byte
    // ****************************************
    logic esb_r;
    logic mav_r;
    logic esb_set;
    logic [7:0] stb_r;
    logic [7:0] stb_low;

    // [RULE14] [RULE15] enabled rising bits
    assign esb_set = |(ev_bits & ~esr_r & ese_r & `TES_ESR_WRITABLE);

    // [RULE16] query or clear resets summary, set wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            esb_r <= 1'b0;
        end else if (esb_set) begin
            esb_r <= 1'b1;
        end else if (esr_clr) begin
            esb_r <= 1'b0;
        end
    end

    // [RULE24] reply available tracking
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mav_r <= 1'b0;
        end else if (reply_placed) begin
            mav_r <= 1'b1;
        end else if (terminator_sent || (cmd.cls && cmd.cls_first)) begin
            mav_r <= 1'b0;
        end
    end

    // [RULE11] summary byte with master summary
    always_comb begin
        stb_low = 8'h00;
        stb_low[`TES_STB_MAV] = mav_r;
        stb_low[`TES_STB_ESB] = esb_r;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stb_r <= 8'h00;
        end else begin
            stb_r <= stb_low | ({7'h00, |(stb_low & sre_r)} << `TES_STB_MSS);
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign meas_start = meas_start_r;
    assign settling = (st_r == TES_ST_SETTLE);
    assign trig_type = type_r;
    assign event_status_latch = esr_r;
    assign esr_read_data = esr_rd_r;
    assign event_enable_mask = ese_r;
    assign service_request_mask = sre_r;
    assign summary_status_byte = stb_r;

    // ****************************************
    // assertions
    // ****************************************
    a_internal_launch: assert property ( // [RULE1]
        @(posedge clk) disable iff (!rst_n)
        (type_r == `TES_TYPE_INTERNAL && !cmd.set_type && int_cnt_r == '0) |=> meas_start_r
    ) else $error("internal launch missing");

    a_ignore_internal: assert property ( // [RULE25]
        @(posedge clk) disable iff (!rst_n)
        (type_r == `TES_TYPE_INTERNAL) |-> !ext_req
    ) else $error("request accepted in internal type");

    a_rear_disabled: assert property ( // [RULE2]
        @(posedge clk) disable iff (!rst_n)
        (is_type(type_r, `TES_TYPE_EXT_FAST, `TES_TYPE_EXT_SETTLE) && !cmd.trg && !key_edge)
        |-> !ext_req
    ) else $error("rear pin accepted with rear disabled");

    a_rear_launch: assert property ( // [RULE3]
        @(posedge clk) disable iff (!rst_n)
        (type_r == `TES_TYPE_REAR_FAST && rear_edge && !cmd.set_type && st_r == TES_ST_IDLE)
        |=> meas_start_r
    ) else $error("rear pulse did not launch");

    a_settle_delay: assert property ( // [RULE4]
        @(posedge clk) disable iff (!rst_n)
        (need_settle && ext_req && st_r == TES_ST_IDLE)
        |=> !meas_start_r && st_r == TES_ST_SETTLE && settle_cnt_r == CW'(SETTLE_CYC - 1)
    ) else $error("settling delay not applied");

    a_cmd_trigger: assert property ( // [RULE5]
        @(posedge clk) disable iff (!rst_n)
        (type_r == `TES_TYPE_EXT_FAST && cmd.trg && !cmd.set_type) |=> meas_start_r
    ) else $error("trigger command ignored");

    a_key_remote: assert property ( // [RULE6]
        @(posedge clk) disable iff (!rst_n)
        (remote_mode && !cmd.trg && !rear_edge) |-> !ext_req
    ) else $error("key accepted in remote");

    a_type_adopt: assert property ( // [RULE8]
        @(posedge clk) disable iff (!rst_n)
        (cmd.set_type && type_ok) |=> type_r == $past(cmd.type_val)
    ) else $error("type not adopted");

    a_event_sticky: assert property ( // [RULE13]
        @(posedge clk) disable iff (!rst_n)
        (esr_r[`TES_EV_DEVICE] && !esr_clr) |=> esr_r[`TES_EV_DEVICE]
    ) else $error("event bit lost");

    a_reserved_zero: assert property ( // [RULE22]
        @(posedge clk) disable iff (!rst_n)
        !esr_r[`TES_EV_UNUSED1] && !esr_r[`TES_EV_UNUSED6]
    ) else $error("reserved event bit set");

    a_query_clear: assert property ( // [RULE23]
        @(posedge clk) disable iff (!rst_n)
        (cmd.esr_query && ev_bits == 8'h00)
        |=> esr_r == 8'h00 && esr_rd_r == $past(esr_r) && !esb_r
    ) else $error("query did not return and clear");

    a_summary_rise: assert property ( // [RULE15]
        @(posedge clk) disable iff (!rst_n)
        esb_set |=> esb_r ##1 stb_r[`TES_STB_ESB]
    ) else $error("summary bit not set");

    a_reply_flag: assert property ( // [RULE24]
        @(posedge clk) disable iff (!rst_n)
        reply_placed |=> mav_r ##1 stb_r[`TES_STB_MAV]
    ) else $error("reply flag not set");
endmodule : tes_top

// ==== test/tes_host_model.sv ====
// host side model: command link pulses and rear trigger pin
`timescale 1ns/10ps
module tes_host_model
    import tes_pkg::*;
(
    // clock
    input wire logic clk,
    // command link
    output tes_cmd_t cmd,
    output tes_events_t events,
    // spare connector pin
    output logic rear_trig_pin
);
    initial begin
        cmd = '0;
        events = '0;
        rear_trig_pin = 1'b0;
    end

    // ****************************************
    // command link
    // ****************************************
    task automatic send(input tes_cmd_t c, input tes_events_t e);
        @(posedge clk);
        cmd <= c;
        events <= e;
        @(posedge clk);
        cmd <= '0;
        events <= '0;
    endtask : send

    task automatic ev(input tes_events_t e);
        send('0, e);
    endtask : ev

    // type command carries type parameter
    // 0 type, 1 trigger, 2 event query, 3 clear, 4 event mask, 5 service mask
    task automatic op(input int k, input logic [7:0] v);
        tes_cmd_t c;
        c = '0;
        c.wdata = v;
        case (k)
            0: begin
                c.set_type = 1'b1;
                c.type_val = v[2:0];
            end
            1: c.trg = 1'b1;
            2: c.esr_query = 1'b1;
            3: begin
                c.cls = 1'b1;
                c.cls_first = v[0];
            end
            4: c.ese_we = 1'b1;
            default: c.sre_we = 1'b1;
        endcase
        send(c, '0);
    endtask : op

    // ****************************************
    // rear trigger pin
    // ****************************************
    // one clean pulse on the spare pin
    task automatic rear_pulse();
        @(posedge clk);
        rear_trig_pin <= 1'b1;
        repeat (8) @(posedge clk);
        rear_trig_pin <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : rear_pulse
endmodule : tes_host_model

// ==== test/trigger_and_event_status_tb.sv ====
// self-checking bench for the trigger and event status block
`timescale 1ns/10ps
`include "tes_defs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
    $display("BAD %0t got %0h exp %0h", $time, a, b); end end
module trigger_and_event_status_tb
    import tes_pkg::*;
;
    localparam int SLOW = 20;
    localparam int MED = 10;
    localparam int FAST = 5;
    localparam int SETTLE = 4;
    localparam int OP_TYPE = 0;
    localparam int OP_TRG = 1;
    localparam int OP_QRY = 2;
    localparam int OP_CLS = 3;
    localparam int OP_ESE = 4;
    localparam int OP_SRE = 5;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic key_trig_pin = 1'b0;
    logic remote_mode = 1'b0;
    logic [1:0] rate_sel = 2'h0;
    logic reply_placed = 1'b0;
    logic terminator_sent = 1'b0;
    tes_cmd_t cmd;
    tes_events_t events;
    logic rear_trig_pin;
    logic meas_start;
    logic settling;
    tes_trig_type_t trig_type;
    logic [7:0] event_status_latch;
    logic [7:0] esr_read_data;
    logic [7:0] event_enable_mask;
    logic [7:0] service_request_mask;
    logic [7:0] summary_status_byte;
    int failures = 0;
    int check_count = 0;
    int meas_cnt = 0;
    int s;
    int per [3] = '{SLOW, MED, FAST};
    logic [7:0] ev_bit [8] = '{8'h01, 8'h04, 8'h04, 8'h04, 8'h08, 8'h08, 8'h10, 8'h20};

    always #20 clk = ~clk;
    // an unknown launch counts, so zero-launch checks cannot pass on X
    always @(posedge clk) if (meas_start !== 1'b0) meas_cnt <= meas_cnt + 1;

    tes_top #(.SLOW_CYC(SLOW), .MEDIUM_CYC(MED), .FAST_CYC(FAST), .SETTLE_CYC(SETTLE)) i_dut (
        .clk(clk), .rst_n(rst_n), .key_trig_pin(key_trig_pin),
        .rear_trig_pin(rear_trig_pin), .remote_mode(remote_mode), .rate_sel(rate_sel),
        .cmd(cmd), .events(events), .reply_placed(reply_placed),
        .terminator_sent(terminator_sent), .meas_start(meas_start), .settling(settling),
        .trig_type(trig_type), .event_status_latch(event_status_latch),
        .esr_read_data(esr_read_data), .event_enable_mask(event_enable_mask),
        .service_request_mask(service_request_mask),
        .summary_status_byte(summary_status_byte));

    tes_host_model i_host (
        .clk(clk), .cmd(cmd), .events(events), .rear_trig_pin(rear_trig_pin));

    // ****************************************
    // helpers
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic count_meas(input int n, input int exp);
        int st;
        st = meas_cnt;
        tick(n);
        `CHK(meas_cnt - st, exp)
    endtask : count_meas

    task automatic press_key();
        @(posedge clk) key_trig_pin <= 1'b1;
        tick(8);
        @(posedge clk) key_trig_pin <= 1'b0;
        tick(8);
    endtask : press_key

    task automatic pin_check(input int rear, input int exp);
        int st;
        st = meas_cnt;
        if (rear != 0) i_host.rear_pulse();
        else press_key();
        tick(4);
        `CHK(meas_cnt - st, exp)
    endtask : pin_check

    task automatic conclude();
        if (failures == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        tick(10);
        `CHK(trig_type, `TES_TYPE_INTERNAL)
        `CHK(event_status_latch, `TES_ESR_RESET)
        `CHK(event_enable_mask, 8'h00)
        `CHK(summary_status_byte, 8'h00)
        @(posedge clk) rst_n <= 1'b1;
        for (int r = 0; r < 3; r++) begin
            @(posedge clk) rate_sel <= 2'(r);
            tick(2 * SLOW);
            count_meas(4 * per[r], 4);
        end
        fork
            count_meas(8 * FAST, 8);
            press_key();
            i_host.rear_pulse();
            repeat (3) i_host.op(OP_TRG, 8'h00);
        join
        i_host.op(OP_TYPE, 8'h02);
        tick(2);
        `CHK(trig_type, `TES_TYPE_EXT_FAST)
        count_meas(3 * SLOW, 0);
        s = meas_cnt;
        i_host.op(OP_TRG, 8'h00);
        #1;
        `CHK(meas_start, 1'b1)
        i_host.op(OP_TRG, 8'h00);
        tick(3);
        `CHK(meas_cnt - s, 2)
        pin_check(1, 0);
        pin_check(0, 1);
        @(posedge clk) remote_mode <= 1'b1;
        pin_check(0, 0);
        i_host.op(OP_TYPE, 8'h04);
        pin_check(1, 1);
        pin_check(0, 0);
        count_meas(2 * SLOW, 0);
        @(posedge clk) remote_mode <= 1'b0;
        pin_check(1, 1);
        for (int t = 3; t <= 5; t += 2) begin
            i_host.op(OP_TYPE, 8'(t));
            s = meas_cnt;
            i_host.op(OP_TRG, 8'h00);
            tick(SETTLE - 1);
            `CHK(settling, 1'b1)
            `CHK(meas_cnt - s, 0)
            tick(4);
            `CHK(meas_cnt - s, 1)
        end
        // event latch: power-on bit, then every event source
        i_host.op(OP_QRY, 8'h00);
        tick(2);
        `CHK(esr_read_data, `TES_ESR_RESET)
        `CHK(event_status_latch, 8'h00)
        for (int i = 0; i < 8; i++) begin
            i_host.ev(tes_events_t'(8'h80 >> i));
            i_host.op(OP_QRY, 8'h00);
            tick(1);
            `CHK(esr_read_data, ev_bit[i])
        end
        i_host.op(OP_ESE, 8'h20);
        tick(2);
        `CHK(event_enable_mask, 8'h20)
        i_host.ev(tes_events_t'(8'h02));
        tick(3);
        `CHK(summary_status_byte[5], 1'b0)
        i_host.ev(tes_events_t'(8'h01));
        tick(3);
        `CHK(summary_status_byte, 8'h20)
        i_host.op(OP_QRY, 8'h00);
        tick(3);
        `CHK(esr_read_data, 8'h30)
        `CHK(summary_status_byte, 8'h00)
        i_host.ev(tes_events_t'(8'h01));
        tick(3);
        i_host.op(OP_CLS, 8'h01);
        tick(3);
        `CHK(event_status_latch, 8'h00)
        `CHK(summary_status_byte, 8'h00)
        i_host.op(OP_TYPE, 8'h06);
        tick(2);
        `CHK(trig_type, `TES_TYPE_REAR_SETTLE)
        `CHK(event_status_latch, 8'h10)
        i_host.op(OP_SRE, 8'h10);
        @(posedge clk) reply_placed <= 1'b1;
        @(posedge clk) reply_placed <= 1'b0;
        tick(3);
        `CHK(service_request_mask, 8'h10)
        `CHK(summary_status_byte, 8'h50)
        // clear-status later in the line keeps the reply flag
        i_host.op(OP_CLS, 8'h00);
        tick(3);
        `CHK(event_status_latch, 8'h00)
        `CHK(summary_status_byte, 8'h50)
        @(posedge clk) terminator_sent <= 1'b1;
        @(posedge clk) terminator_sent <= 1'b0;
        tick(3);
        `CHK(summary_status_byte, 8'h00)
        // clear-status first in the line drops the reply flag
        @(posedge clk) reply_placed <= 1'b1;
        @(posedge clk) reply_placed <= 1'b0;
        i_host.op(OP_CLS, 8'h01);
        tick(3);
        `CHK(summary_status_byte, 8'h00)
        // mid-run reset returns every register to its power-on value
        @(posedge clk) rst_n <= 1'b0;
        tick(3);
        `CHK(event_status_latch, `TES_ESR_RESET)
        `CHK(esr_read_data, 8'h00)
        `CHK(event_enable_mask, 8'h00)
        `CHK(service_request_mask, 8'h00)
        `CHK(trig_type, `TES_TYPE_INTERNAL)
        @(posedge clk) rst_n <= 1'b1;
        count_meas(4 * FAST, 4);
        conclude();
    end

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        conclude();
    end
endmodule : trigger_and_event_status_tb
